// [hw/tap_pkg.sv]
// constants shared by the test port device end and the tester end
// assumes both ends compile against this package first
package tap_pkg;
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BSR_W_DEF = 16;
   localparam int RESET_TMS_CNT = 5;
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
   localparam logic [2:0] IR_SAMPLE = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
   // identification value is arbitrary
   localparam logic [31:0] ID_VALUE_DEF = 32'h1234_5A5B;
   localparam int TCK_DIV_DEF = 8;
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
   } tap_state_t;
endpackage

// [hw/tap_if.sv]
// test link wires between tester and device end
// assumes the tester resolves the data out wire from its enable
`timescale 1ns/1ps
interface tap_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe_n;
   modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
   modport tst (output tck, output tms, output tdi, input tdo, input tdo_oe_n);
endinterface

// [hw/tap_tester.sv]
// tester end: makes the test clock by a divider, shifts words through the port
// assumes requests hold until accepted; drive one request at a time
`timescale 1ns/1ps
module tap_tester
   import tap_pkg::*;
#(
   parameter int DIV = TCK_DIV_DEF,
   parameter int MAX_W = 64
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   tap_if.tst link,
   input wire logic req_valid_in,
   input wire logic req_ir_in,
   input wire logic req_reset_in,
   input wire logic [7:0] req_len_in,
   input wire logic [MAX_W-1:0] req_data_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [MAX_W-1:0] rsp_data_out
);
   if (DIV < 2 || DIV > 256 || MAX_W < 1 || MAX_W > 255) begin : bad_params_chk
      $error("bad tester parameters");
   end
   // step counters: tms steps before the shift, bits left to shift, tms steps after
   logic [7:0] div_r;
   logic tck_r, tms_r, tdi_r, busy_r;
   logic [3:0] pre_r;
   logic [7:0] left_r;
   logic [2:0] post_r;
   logic [MAX_W-1:0] sh_r, cap_r;
   logic is_ir_r, rst_req_r, armed_r;
   logic [7:0] len_r;
   logic rise, fall;
   assign rise = (div_r == 8'(DIV - 1)) && !tck_r;
   assign fall = (div_r == 8'(DIV - 1)) && tck_r;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_r <= 8'h00;
         tck_r <= 1'b0;
      end else if (div_r == 8'(DIV - 1)) begin
         div_r <= 8'h00;
         tck_r <= !tck_r;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         busy_r <= 1'b0;
         tms_r <= 1'b1;
         tdi_r <= 1'b1;
         pre_r <= 4'h0;
         left_r <= 8'h00;
         post_r <= 3'h0;
         sh_r <= '0;
         cap_r <= '0;
         is_ir_r <= 1'b0;
         rst_req_r <= 1'b0;
         armed_r <= 1'b0;
         len_r <= 8'h00;
         rsp_valid_out <= 1'b0;
         rsp_data_out <= '0;
         req_ready_out <= 1'b0;
      end else begin
         rsp_valid_out <= 1'b0;
         req_ready_out <= !busy_r && !req_ready_out;
         if (req_valid_in && req_ready_out) begin
            busy_r <= 1'b1;
            req_ready_out <= 1'b0;
            rst_req_r <= req_reset_in;
            is_ir_r <= req_ir_in;
            armed_r <= 1'b0;
            len_r <= req_len_in;
            sh_r <= req_data_in;
            left_r <= req_reset_in ? 8'h00 : req_len_in;
            pre_r <= req_reset_in ? 4'(RESET_TMS_CNT) : (req_ir_in ? 4'h5 : 4'h4);
            post_r <= req_reset_in ? 3'h0 : 3'h2;
            cap_r <= '0;
         end else if (busy_r && fall) begin
            // tms and tdi change on the falling edge, far from the sampling edge
            armed_r <= 1'b1;
            if (rst_req_r) begin
               tms_r <= 1'b1;
            end else if (pre_r != 4'h0) begin
               // idle: 0, then select dr (1), [select ir (1)], capture (0), shift(0)
               case (pre_r)
                  4'h4: tms_r <= is_ir_r;
                  4'h3: tms_r <= 1'b1;
                  default: tms_r <= 1'b0;
               endcase
               if (pre_r == 4'h1) tdi_r <= sh_r[0];
            end else if (left_r != 8'h00) begin
               tms_r <= (left_r == 8'h01);
               tdi_r <= sh_r[0];
            end else begin
               tms_r <= (post_r == 3'h2);
            end
         end else if (busy_r && armed_r && rise) begin
            // a rise before the first fall of a request still carries the old tms
            if (pre_r != 4'h0) begin
               pre_r <= pre_r - 4'h1;
               if (pre_r == 4'h1 && rst_req_r) begin
                  busy_r <= 1'b0;
                  rsp_valid_out <= 1'b1;
               end
            end else if (left_r != 8'h00) begin
               // lsb first out
               // a released tdo reads as the inverse of its last value
               cap_r <= {link.tdo_oe_n ? !link.tdo : link.tdo, cap_r[MAX_W-1:1]};
               sh_r <= {1'b1, sh_r[MAX_W-1:1]};
               left_r <= left_r - 8'h01;
            end else if (post_r != 3'h0) begin
               post_r <= post_r - 3'h1;
            end else begin
               busy_r <= 1'b0;
               rsp_valid_out <= 1'b1;
               // first bit out lands at bit 0
               rsp_data_out <= cap_r >> (8'(MAX_W) - len_r);
               tms_r <= 1'b0;
            end
         end
      end
   end
   assign link.tck = tck_r;
   assign link.tms = tms_r;
   assign link.tdi = tdi_r;
endmodule // tap_tester

// [hw/tap_device.sv]
// device end: test access port of a synchronous memory
// assumes tck is slow against clk_sys_in; samples all link pins by two flops
// Functional notes
// - sample on rising, drive on falling
// - undriven tms and tdi read high
// - shift in at msb, out lsb
// - data out enabled only while shifting
// - five tms high clocks reach reset
// - port reset leaves memory path alone
// - power up resets port, output off
// - instruction selects exactly one register
// - three bit instruction shifted serially
// - identify instruction after any reset
// - capture ir loads 01 low bits
// - one bit bypass register
// - bypass bit cleared on bypass
// - boundary captures ring, then shifts
// - extest, sample, sample z capture ring
// - one cell per input and io ball
// - id loads 32 bits, shifts out
// - id is fixed built in constant
// - held tck keeps reset state
// - tester advised bypass only
// - sample z floats memory outputs
// - extest drives preloaded cells out
`timescale 1ns/1ps
module tap_device
   import tap_pkg::*;
#(
   parameter int BSR_W = BSR_W_DEF,
   parameter int OUT_W = 8,
   parameter logic [31:0] ID_VALUE = ID_VALUE_DEF
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   tap_if.dev link,
   input wire logic tms_driven_in,
   input wire logic tdi_driven_in,
   input wire logic [BSR_W-1:0] ring_in,
   input wire logic [OUT_W-1:0] core_out_in,
   input wire logic core_oe_in,
   output logic [OUT_W-1:0] pin_out_out,
   output logic pin_oe_n_out,
   output logic cap_valid_out,
   output logic [BSR_W-1:0] cap_data_out,
   input wire logic cap_ready_in
);
   if (BSR_W < OUT_W + 1 || OUT_W < 1) begin : bad_width_chk
      $error("boundary register too short");
   end
   // bit BSR_W-1 is the output enable cell, low bits the output cells
   logic [2:0] tck_s, tms_s, tdi_s;
   logic tck_rise, tck_fall, tms_v, tdi_v;
   tap_state_t st_r, st_nxt;
   logic [IR_W-1:0] ir_sh_r, ir_r;
   logic bypass_r;
   logic [ID_W-1:0] id_r;
   logic [BSR_W-1:0] bsr_r, pre_r;
   logic tdo_r, tdo_oe_n_r, serial_bit;
   logic [BSR_W-1:0] buf0_r, buf1_r;
   logic [1:0] cnt_r;
   logic buf_push, buf_pop;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tck_s <= 3'h0;
         tms_s <= 3'h7;
         tdi_s <= 3'h7;
      end else begin
         tck_s <= {tck_s[1:0], link.tck};
         tms_s <= {tms_s[1:0], link.tms | !tms_driven_in};
         tdi_s <= {tdi_s[1:0], link.tdi | !tdi_driven_in};
      end
   end
   assign tck_rise = tck_s[1] && !tck_s[2];
   assign tck_fall = !tck_s[1] && tck_s[2];
   assign tms_v = tms_s[1];
   assign tdi_v = tdi_s[1];
   always_comb begin
      case (st_r)
         ST_RESET: st_nxt = tms_v ? ST_RESET : ST_IDLE;
         ST_IDLE: st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: st_nxt = tms_v ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: st_nxt = tms_v ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: st_nxt = tms_v ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: st_nxt = tms_v ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: st_nxt = tms_v ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: st_nxt = tms_v ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: st_nxt = tms_v ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: st_nxt = tms_v ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         default: st_nxt = ST_RESET;
      endcase
   end
   // five high tms clocks walk any state to reset
   // power up reset; no tck edge keeps it there
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) st_r <= ST_RESET;
      else if (tck_rise) st_r <= st_nxt;
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ir_sh_r <= IR_IDCODE;
      end else if (tck_rise) begin
         if (st_r == ST_CAP_IR) ir_sh_r <= {1'b0, IR_CAPTURE_PAT};
         else if (st_r == ST_SH_IR) ir_sh_r <= {tdi_v, ir_sh_r[IR_W-1:1]};
      end
   end
   // update ir only; reset loads identify
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) ir_r <= IR_IDCODE;
      else if (tck_rise && st_r == ST_RESET) ir_r <= IR_IDCODE;
      else if (tck_rise && st_r == ST_UPD_IR) ir_r <= ir_sh_r;
   end
   // bypass cell; cleared when bypass acts
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) bypass_r <= 1'b0;
      else if (tck_rise && st_r == ST_CAP_DR) bypass_r <= 1'b0;
      else if (tck_rise && st_r == ST_SH_DR) bypass_r <= tdi_v;
   end
   // identify capture and shift; fixed value
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) id_r <= '0;
      else if (tck_rise && st_r == ST_CAP_DR) id_r <= ID_VALUE;
      else if (tck_rise && st_r == ST_SH_DR) id_r <= {tdi_v, id_r[ID_W-1:1]};
   end
   // boundary capture of ring, then shift
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         bsr_r <= '0;
      end else if (tck_rise && (ir_r == IR_EXTEST || ir_r == IR_SAMPLE ||
                                ir_r == IR_SAMPLE_Z)) begin
         if (st_r == ST_CAP_DR) bsr_r <= ring_in;
         else if (st_r == ST_SH_DR) bsr_r <= {tdi_v, bsr_r[BSR_W-1:1]};
      end
   end
   // preload latch; enable cell preset high in reset
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pre_r <= {1'b1, {(BSR_W-1){1'b0}}};
      end else if (tck_rise && st_r == ST_RESET) begin
         pre_r[BSR_W-1] <= 1'b1;
      end else if (tck_rise && st_r == ST_UPD_DR && (ir_r == IR_EXTEST ||
                   ir_r == IR_SAMPLE)) begin
         pre_r <= bsr_r;
      end
   end
   always_comb begin
      if (st_r == ST_SH_IR) serial_bit = ir_sh_r[0];
      else begin
         case (ir_r)
            IR_IDCODE: serial_bit = id_r[0];
            IR_EXTEST, IR_SAMPLE, IR_SAMPLE_Z: serial_bit = bsr_r[0];
            default: serial_bit = bypass_r;
         endcase
      end
   end
   // output on falling edge, enabled only while shifting
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tdo_r <= 1'b0;
         tdo_oe_n_r <= 1'b1;
      end else if (tck_fall) begin
         tdo_r <= serial_bit;
         tdo_oe_n_r <= !(st_r == ST_SH_DR || st_r == ST_SH_IR);
      end
   end
   assign link.tdo = tdo_r;
   assign link.tdo_oe_n = tdo_oe_n_r;
   // memory path passes through unless a test instruction claims it
   // sample z floats; extest drives preload
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pin_out_out <= '0;
         pin_oe_n_out <= 1'b1;
      end else if (ir_r == IR_SAMPLE_Z) begin
         pin_out_out <= core_out_in;
         pin_oe_n_out <= 1'b1;
      end else if (ir_r == IR_EXTEST) begin
         pin_out_out <= pre_r[OUT_W-1:0];
         pin_oe_n_out <= !pre_r[BSR_W-1];
      end else begin
         pin_out_out <= core_out_in;
         pin_oe_n_out <= !core_oe_in;
      end
   end
   // two entry buffer for captured ring words; a capture into a full buffer is dropped
   assign buf_push = tck_rise && st_r == ST_CAP_DR && ir_r != IR_IDCODE &&
                     ir_r != IR_BYPASS && cnt_r != 2'h2;
   assign buf_pop = cap_valid_out && cap_ready_in;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         buf0_r <= '0;
         buf1_r <= '0;
         cnt_r <= 2'h0;
         cap_valid_out <= 1'b0;
         cap_data_out <= '0;
      end else begin
         if (buf_push && !buf_pop) begin
            if (cnt_r == 2'h0) buf0_r <= ring_in;
            else buf1_r <= ring_in;
            cnt_r <= cnt_r + 2'h1;
         end else if (buf_pop && !buf_push) begin
            buf0_r <= buf1_r;
            cnt_r <= cnt_r - 2'h1;
         end else if (buf_pop && buf_push) begin
            if (cnt_r == 2'h1) buf0_r <= ring_in;
            else begin
               buf0_r <= buf1_r;
               buf1_r <= ring_in;
            end
         end
         cap_valid_out <= (cnt_r != 2'h0 && !(buf_pop && !buf_push && cnt_r == 2'h1)) ||
                          (buf_push && cnt_r == 2'h0);
         if (buf_pop || cnt_r == 2'h0) begin
            cap_data_out <= (cnt_r == 2'h2) ? buf1_r : ring_in;
         end else begin
            cap_data_out <= buf0_r;
         end
      end
   end
endmodule // tap_device

// [dv/tap_link_props.sv]
// checker of the test link between the tester end and the device end
// assumes a tck low phase of at least eight system clocks
`timescale 1ns/1ps
module tap_link_props
   import tap_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire logic tms_driven_in,
   input wire logic tdi_driven_in
);
   logic [2:0] tck_s_r, sh_r, kn_r, hi_r, ir_r;
   logic [5:0] cnt_r;
   logic byp_r;
   tap_state_t st_r, st_nxt;
   wire tms_e = tms | ~tms_driven_in;
   wire tdi_e = tdi | ~tdi_driven_in;
   wire rise = tck_s_r[1] & ~tck_s_r[2];
   wire fall = tck_s_r[2] & ~tck_s_r[1];
   wire sh_ir = st_r == ST_SH_IR;
   wire sh_dr = st_r == ST_SH_DR;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   function automatic tap_state_t step_st(input tap_state_t s, input logic m);
      case (s)
         ST_RESET: return m ? ST_RESET : ST_IDLE;
         ST_IDLE: return m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR, ST_SH_DR: return m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: return m ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: return m ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
         ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR, ST_SH_IR: return m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: return m ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: return m ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
         default: return m ? ST_SEL_DR : ST_IDLE;
      endcase
   endfunction
   assign st_nxt = step_st(st_r, tms_e);
   // reference state, instruction and shift path seen from the link
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tck_s_r <= 3'h0;
         st_r <= ST_RESET;
         cnt_r <= 6'h0;
         ir_r <= IR_IDCODE;
         sh_r <= 3'h0;
         kn_r <= 3'h0;
         hi_r <= 3'h0;
         byp_r <= 1'b0;
      end else begin
         tck_s_r <= {tck_s_r[1:0], tck};
         if (rise) begin
            st_r <= st_nxt;
            cnt_r <= (sh_ir | sh_dr) ? cnt_r + 6'h1 : 6'h0;
            hi_r <= !tms_e ? 3'h0 : (hi_r == 3'h5 ? hi_r : hi_r + 3'h1);
            if (st_r == ST_CAP_IR) begin
               sh_r <= {1'b0, IR_CAPTURE_PAT};
               kn_r <= 3'h3;
            end
            if (sh_ir) begin
               sh_r <= {tdi_e, sh_r[2:1]};
               kn_r <= {1'b1, kn_r[2:1]};
            end
            if (st_r == ST_CAP_DR) byp_r <= 1'b0;
            if (sh_dr) byp_r <= tdi_e;
            if (st_nxt == ST_UPD_IR) ir_r <= sh_r;
            if (st_nxt == ST_RESET) ir_r <= IR_IDCODE;
         end
      end
   end
   tdo_fall_only_a: assert property ($changed(tdo) |-> !tck)
      else $error("tdo moved while tck high");
   oe_fall_only_a: assert property ($changed(tdo_oe_n) |-> !tck)
      else $error("tdo enable moved while tck high");
   oe_shift_only_a: assert property (fall |-> ##5 (tdo_oe_n == !(sh_ir | sh_dr)))
      else $error("tdo enable wrong for state");
   five_tms_reset_a: assert property (rise && tms_e && hi_r == 3'h4 |-> ##4 tdo_oe_n [*8])
      else $error("tdo enabled after five tms high");
   power_up_off_a: assert property ($fell(rst_in) |-> tdo_oe_n [*4])
      else $error("tdo enabled after reset");
   ir_shift_out_a: assert property (fall && sh_ir && kn_r[0] |-> ##5 (tdo == sh_r[0]))
      else $error("instruction shift bit wrong");
   bypass_path_a: assert property (fall && sh_dr && ir_r == IR_BYPASS |-> ##5 (tdo == byp_r))
      else $error("bypass bit wrong");
   id_shift_a: assert property (fall && sh_dr && ir_r == IR_IDCODE && cnt_r < 6'h20
      |-> ##5 (tdo == ID_VALUE_DEF[cnt_r[4:0]]))
      else $error("identification bit wrong");
   ir_cap_c: cover property (rise && st_r == ST_CAP_IR);
   byp_sh_c: cover property (fall && sh_dr && ir_r == IR_BYPASS);
   tap_rst_c: cover property (hi_r == 3'h5);
endmodule // tap_link_props

// [dv/sram_boundary_scan_tap_tb.sv]
// bench: tester end and device end face each other over the link
// assumes the tester returns tdo bits lsb first in its response word
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb
   import tap_pkg::*;
;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, req_valid = 1'b0, req_ir = 1'b0, req_rst = 1'b0;
   logic tms_drv = 1'b1, tdi_drv = 1'b1, core_oe = 1'b0, cap_ready = 1'b0, oe_seen = 1'b0;
   logic req_ready, rsp_valid, cap_valid, pin_oe_n;
   logic [7:0] req_len = 8'h0, core = 8'h0, pins, d;
   logic [63:0] req_data = 64'h0, rsp_data, q;
   logic [15:0] ring = 16'h0, cap_data, p;
   logic [15:0] rings [3];
   logic [2:0] codes [3] = '{IR_SAMPLE, IR_EXTEST, IR_SAMPLE_Z};
   wire [8:0] pad = {pin_oe_n, pins};
   int error_cnt = 0, n_compared = 0;
   tap_if link_if();
   tap_tester i_tap_tester (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link_if.tst),
      .req_valid_in(req_valid), .req_ir_in(req_ir), .req_reset_in(req_rst), .req_len_in(req_len),
      .req_data_in(req_data), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data));
   tap_device i_tap_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link_if.dev),
      .tms_driven_in(tms_drv), .tdi_driven_in(tdi_drv), .ring_in(ring), .core_out_in(core),
      .core_oe_in(core_oe), .pin_out_out(pins), .pin_oe_n_out(pin_oe_n),
      .cap_valid_out(cap_valid), .cap_data_out(cap_data), .cap_ready_in(cap_ready));
   tap_link_props i_tap_link_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .tck(link_if.tck), .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo),
      .tdo_oe_n(link_if.tdo_oe_n), .tms_driven_in(tms_drv), .tdi_driven_in(tdi_drv));
   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      if (!tms_drv && link_if.tdo_oe_n === 1'b0) oe_seen <= 1'b1;
   end
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic scan(input logic ir, input logic rs, input logic [7:0] len,
         input logic [63:0] dat, output logic [63:0] res);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_ir <= ir;
      req_rst <= rs;
      req_len <= len;
      req_data <= dat;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (req_ready !== 1'b1 && n < 9000);
      req_valid <= 1'b0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (rsp_valid !== 1'b1 && n < 9000);
      res = rsp_data;
      if (n >= 9000) begin
         error_cnt++;
         test_done();
      end
   endtask
   initial begin
      void'($urandom(34431));
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      scan(1'b0, 1'b0, 8'h20, 64'h0, q);
      check("id after power up", q[31:0], ID_VALUE_DEF);
      scan(1'b1, 1'b0, 8'h3, {61'h0, IR_BYPASS}, q);
      check("ir capture pattern", q[1:0], IR_CAPTURE_PAT);
      d = 8'($urandom);
      scan(1'b0, 1'b0, 8'h8, {56'h0, d}, q);
      check("bypass delay", q[7:0], {d[6:0], 1'b0});
      core <= 8'($urandom);
      core_oe <= 1'b1;
      scan(1'b0, 1'b1, 8'h0, 64'h0, q);
      check("pins during port reset", pad, {1'b0, core});
      scan(1'b0, 1'b0, 8'h20, 64'h0, q);
      check("id after port reset", q[31:0], ID_VALUE_DEF);
      p = 16'($urandom);
      for (int k = 0; k < 3; k++) begin
         scan(1'b1, 1'b0, 8'h3, {61'h0, codes[k]}, q);
         rings[k] = 16'($urandom);
         ring <= rings[k];
         scan(1'b0, 1'b0, 8'h10, {48'h0, p}, q);
         check("ring capture", q[15:0], rings[k]);
         if (codes[k] == IR_EXTEST) check("extest pins", pad, {~p[15], p[7:0]});
         if (codes[k] == IR_SAMPLE_Z) check("sample z float", pin_oe_n, 1'b1);
      end
      for (int k = 0; k < 3; k++) begin
         check("buffer valid", cap_valid, {63'h0, k < 2});
         if (k < 2) check("buffer word", cap_data, rings[k]);
         cap_ready <= 1'b1;
         @(posedge clk_sys_in);
         cap_ready <= 1'b0;
         @(posedge clk_sys_in);
      end
      tms_drv <= 1'b0;
      scan(1'b1, 1'b0, 8'h3, {61'h0, IR_BYPASS}, q);
      check("tms undriven stays out of shift", oe_seen, 1'b0);
      tms_drv <= 1'b1;
      scan(1'b0, 1'b1, 8'h0, 64'h0, q);
      scan(1'b1, 1'b0, 8'h3, {61'h0, IR_BYPASS}, q);
      core <= 8'($urandom);
      tdi_drv <= 1'b0;
      scan(1'b0, 1'b0, 8'h8, 64'h0, q);
      check("tdi undriven reads high", q[7:0], 8'hFE);
      tdi_drv <= 1'b1;
      check("pins follow memory", pad, {1'b0, core});
      test_done();
   end
endmodule // sram_boundary_scan_tap_tb
